// File: hdl/egress_qos_scheduler.sv
`timescale 1ns/10ps
`default_nettype none
module egress_qos_scheduler
  import egress_sched_pkg::*;
#(
  parameter int NI = NUM_INGRESS,
  parameter int NC = NUM_CLASS
) (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic [11:0]                   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [NI-1:0][NC-1:0]         q_valid,
  input  wire logic [NI-1:0][NC-1:0][LEN_W-1:0] q_len,
  output logic                               q_pop,
  output grant_t                             q_pop_sel,
  output logic                               frame_valid,
  input  wire logic                          frame_ready,
  output grant_t                             frame_info,
  input  wire logic                          frame_done,
  input  wire logic                          pause_active
);

  sched_state_t          state_q;
  grant_t                grant_q;
  logic [1:0]            mode_q;
  logic [3:0]            boundary_q;
  logic [31:0]           weight_lo_q;
  logic [31:0]           weight_hi_q;
  shaper_cfg_t           port_shp_q;
  shaper_cfg_t [NC-1:0]  class_shp_q;
  logic [31:0]           frames_q;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;
  logic [NC-1:0][2:0]    ing_ptr_q;
  logic [2:0]            cls_ptr_q;
  logic [NC-1:0][DEF_W-1:0] deficit_q;
  logic [7:0]            tick_cnt_q;
  logic                  tick;
  logic [NC-1:0]         class_pend;
  logic [NC-1:0]         class_shaped;
  logic [NC-1:0]         class_elig;
  logic [NC-1:0]         strict_mask;
  logic [NC-1:0]         strict_elig;
  logic [NC-1:0]         wrr_elig;
  logic [NC-1:0][2:0]    ing_sel;
  logic [NC-1:0][LEN_W-1:0] head_len;
  logic                  port_shaped;
  logic                  gate;
  logic                  grant_go;
  logic                  pick_strict;
  logic [2:0]            pick_cls;
  logic [2:0]            hi_cls;
  logic [3:0]            frr_pick;
  logic                  dwrr_step;
  logic                  taken;
  logic [NC-1:0][WEIGHT_W-1:0] weight;

  // Round-robin search upward from ptr, wrapping
  function automatic logic [3:0] rr_pick(input logic [7:0] mask,
                                         input logic [2:0] ptr);
    logic [2:0] idx;
    rr_pick = 4'h0;
    for (int k = 7; k >= 0; k--) begin
      idx = ptr + 3'(k);
      if (mask[idx]) begin
        rr_pick = {1'b1, idx};
      end
    end
  endfunction : rr_pick

  // Class inputs from per-ingress queues
  genvar gc;
  generate
    for (gc = 0; gc < NC; gc++) begin : g_class
      logic [7:0] imask;
      logic [3:0] ipick;
      always_comb begin
        imask = 8'h00;
        for (int i = 0; i < NI; i++) begin
          imask[i] = q_valid[i][gc];
        end
      end
      assign ipick          = rr_pick(imask, ing_ptr_q[gc]);
      assign ing_sel[gc]    = ipick[2:0];
      assign class_pend[gc] = ipick[3];
      assign head_len[gc]   = q_len[ing_sel[gc]][gc];
      assign weight[gc]     = (gc < 4) ?
        weight_lo_q[(gc%4)*8 +: WEIGHT_W] :
        weight_hi_q[(gc%4)*8 +: WEIGHT_W];
      assign strict_mask[gc] = (mode_q == MODE_STRICT) ||
                               (4'(gc) >= boundary_q);

      leaky_bucket u_class_shaper (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .tick       (tick),
        .cfg        (class_shp_q[gc]),
        .charge     (taken && grant_q.cls == 3'(gc)),
        .charge_len (grant_q.len),
        .over       (class_shaped[gc])
      );
    end
  endgenerate

  leaky_bucket u_port_shaper (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .tick       (tick),
    .cfg        (port_shp_q),
    .charge     (taken),
    .charge_len (grant_q.len),
    .over       (port_shaped)
  );

  // Shaper tick divider
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= 8'h00;
    end else if (tick) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end
  assign tick = (tick_cnt_q == 8'(SHAPER_TICK_CYC - 1));

  // Eligibility and selection
  assign class_elig  = class_pend & ~class_shaped;
  assign strict_elig = class_elig & strict_mask;
  assign wrr_elig    = class_elig & ~strict_mask;
  assign gate = (state_q == ST_IDLE) && !pause_active && !port_shaped;
  assign frr_pick = rr_pick(8'(wrr_elig), cls_ptr_q);

  always_comb begin
    hi_cls = 3'h0;
    for (int c = 0; c < NC; c++) begin
      if (strict_elig[c]) begin
        hi_cls = 3'(c);
      end
    end
  end

  always_comb begin
    grant_go    = 1'b0;
    pick_strict = 1'b0;
    pick_cls    = 3'h0;
    dwrr_step   = 1'b0;
    if (gate && |strict_elig) begin
      grant_go    = 1'b1;
      pick_strict = 1'b1;
      pick_cls    = hi_cls;
    end else if (gate && mode_q == MODE_FRR && frr_pick[3]) begin
      grant_go = 1'b1;
      pick_cls = frr_pick[2:0];
    end else if (gate && mode_q == MODE_DWRR && |wrr_elig) begin
      if (wrr_elig[cls_ptr_q] &&
          deficit_q[cls_ptr_q] >= DEF_W'(head_len[cls_ptr_q])) begin
        grant_go = 1'b1;
        pick_cls = cls_ptr_q;
      end else begin
        dwrr_step = 1'b1;
      end
    end
  end

  // Deficit counters
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      deficit_q <= '0;
    end else if (mode_q != MODE_DWRR) begin
      deficit_q <= '0;
    end else if (grant_go && !pick_strict) begin
      deficit_q[pick_cls] <= deficit_q[pick_cls] -
                             DEF_W'(head_len[pick_cls]);
    end else if (dwrr_step) begin
      if (wrr_elig[cls_ptr_q]) begin
        deficit_q[cls_ptr_q] <= deficit_q[cls_ptr_q] +
          DEF_W'(weight[cls_ptr_q]) * DEF_W'(QUANTUM_BYTES);
      end else begin
        deficit_q[cls_ptr_q] <= '0;
      end
    end
  end

  // Class round-robin pointer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cls_ptr_q <= 3'h0;
    end else if (dwrr_step) begin
      cls_ptr_q <= cls_ptr_q + 3'h1;
    end else if (grant_go && !pick_strict && mode_q == MODE_FRR) begin
      cls_ptr_q <= pick_cls + 3'h1;
    end
  end

  // Ingress pointers advance past the served queue
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ing_ptr_q <= '0;
    end else if (grant_go) begin
      ing_ptr_q[pick_cls] <= ing_sel[pick_cls] + 3'h1;
    end
  end

  // Frame offer state machine
  assign taken = (state_q == ST_OFFER) && frame_ready;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (grant_go) begin
            state_q <= ST_OFFER;
          end
        end
        ST_OFFER: begin
          if (frame_ready) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (frame_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      grant_q <= '0;
    end else if (grant_go) begin
      grant_q.ingress <= ing_sel[pick_cls];
      grant_q.cls     <= pick_cls;
      grant_q.len     <= head_len[pick_cls];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frames_q <= 32'h00000000;
    end else if (taken) begin
      frames_q <= frames_q + 32'h00000001;
    end
  end

  assign frame_valid = (state_q == ST_OFFER);
  assign frame_info  = grant_q;
  assign q_pop       = taken;
  assign q_pop_sel   = grant_q;

  // APB register writes
  logic wr_en;
  assign wr_en = psel && penable && pwrite;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q      <= RST_MODE;
      boundary_q  <= RST_BOUNDARY;
      weight_lo_q <= RST_WEIGHT;
      weight_hi_q <= RST_WEIGHT;
      port_shp_q  <= RST_SHAPER[$bits(shaper_cfg_t)-1:0];
      class_shp_q <= '0;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL) begin
        mode_q     <= pwdata[CTRL_MODE_LSB +: 2];
        boundary_q <= pwdata[CTRL_BND_LSB +: 4];
      end else if (paddr == OFF_WEIGHT_LO) begin
        weight_lo_q <= pwdata & 32'h1f1f1f1f;
      end else if (paddr == OFF_WEIGHT_HI) begin
        weight_hi_q <= pwdata & 32'h1f1f1f1f;
      end else if (paddr == OFF_PORT_SHP) begin
        port_shp_q <= {pwdata[SHP_EN_BIT], pwdata[SHP_RATE_LSB +: RATE_W],
                       pwdata[SHP_LIM_LSB +: LIM_W]};
      end else if (paddr >= OFF_CLASS_SHP && paddr < OFF_STATUS &&
                   paddr[1:0] == 2'b00) begin
        class_shp_q[3'(paddr[11:2] - OFF_CLASS_SHP[11:2])] <=
          {pwdata[SHP_EN_BIT], pwdata[SHP_RATE_LSB +: RATE_W],
           pwdata[SHP_LIM_LSB +: LIM_W]};
      end
    end
  end

  // Read data captured in the setup cycle
  function automatic logic [31:0] shp_word(input shaper_cfg_t s);
    shp_word = '0;
    shp_word[SHP_EN_BIT] = s.en;
    shp_word[SHP_RATE_LSB +: RATE_W] = s.rate;
    shp_word[SHP_LIM_LSB +: LIM_W]   = s.limit;
  endfunction : shp_word

  logic [31:0] rd_word;
  logic        rd_err;
  always_comb begin
    rd_word = 32'h00000000;
    rd_err  = 1'b0;
    if (paddr == OFF_CTRL) begin
      rd_word[CTRL_MODE_LSB +: 2] = mode_q;
      rd_word[CTRL_BND_LSB +: 4]  = boundary_q;
    end else if (paddr == OFF_WEIGHT_LO) begin
      rd_word = weight_lo_q;
    end else if (paddr == OFF_WEIGHT_HI) begin
      rd_word = weight_hi_q;
    end else if (paddr == OFF_PORT_SHP) begin
      rd_word = shp_word(port_shp_q);
    end else if (paddr >= OFF_CLASS_SHP && paddr < OFF_STATUS &&
                 paddr[1:0] == 2'b00) begin
      rd_word = shp_word(class_shp_q[3'(paddr[11:2] - OFF_CLASS_SHP[11:2])]);
    end else if (paddr == OFF_STATUS) begin
      rd_word[ST_PEND_LSB +: 8]   = 8'(class_pend);
      rd_word[ST_SHAPED_LSB +: 8] = 8'(class_shaped);
      rd_word[ST_PORT_BIT]        = port_shaped;
      rd_word[ST_PAUSE_BIT]       = pause_active;
      rd_word[ST_BUSY_BIT]        = (state_q != ST_IDLE);
    end else if (paddr == OFF_FRAMES) begin
      rd_word = frames_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h00000000 : rd_word;
      pslverr_q <= rd_err;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign pready  = 1'b1;

  a_grant_valid_q: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    grant_go |-> q_valid[ing_sel[pick_cls]][pick_cls])
    else $error("grant of empty queue");
  a_ingress_rr_step: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    grant_go |=> ing_ptr_q[grant_q.cls] == grant_q.ingress + 3'h1)
    else $error("ingress pointer not advanced");
  a_strict_highest: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    grant_go && pick_strict |-> (strict_elig >> (4'(pick_cls) + 4'h1)) == '0)
    else $error("lower strict class served first");
  a_weighted_only: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    grant_go && !pick_strict |-> strict_elig == 0 && !strict_mask[pick_cls])
    else $error("shared class served over strict");
  a_dwrr_deficit: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    grant_go && !pick_strict && mode_q == MODE_DWRR
    |=> deficit_q[grant_q.cls] ==
        $past(deficit_q[pick_cls]) - DEF_W'(grant_q.len))
    else $error("deficit not charged by length");
  a_shaped_blocked: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    grant_go |-> !class_shaped[pick_cls] && !port_shaped)
    else $error("shaped traffic granted");
  a_pause_stops: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    pause_active && state_q == ST_IDLE |=> state_q == ST_IDLE)
    else $error("frame offered during pause");
  a_no_split: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_q == ST_BUSY && !frame_done |=> state_q == ST_BUSY && !frame_valid)
    else $error("new frame before done");
  a_offer_held: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    frame_valid && !frame_ready |=> frame_valid && $stable(frame_info))
    else $error("offer dropped or changed");

endmodule : egress_qos_scheduler
`default_nettype wire

// File: hdl/egress_sched_pkg.sv
`default_nettype none
package egress_sched_pkg;

  // Clock and shaper tick
  localparam int CLK_MHZ         = 250;
  localparam int SHAPER_TICK_NS  = 1000;
  localparam int SHAPER_TICK_CYC = (SHAPER_TICK_NS * CLK_MHZ + 999) / 1000;

  // Geometry
  localparam int NUM_CLASS    = 8;
  localparam int NUM_INGRESS  = 4;
  localparam int LEN_W        = 14;
  localparam int DEF_W        = 18;
  localparam int LVL_W        = 24;
  localparam int RATE_W       = 12;
  localparam int LIM_W        = 16;
  localparam int WEIGHT_W     = 5;
  localparam int QUANTUM_BYTES = 64;
  localparam int BUFFER_BITS  = 1835008;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_WEIGHT_LO = 12'h004;
  localparam logic [11:0] OFF_WEIGHT_HI = 12'h008;
  localparam logic [11:0] OFF_PORT_SHP  = 12'h00c;
  localparam logic [11:0] OFF_CLASS_SHP = 12'h010;
  localparam logic [11:0] OFF_STATUS    = 12'h030;
  localparam logic [11:0] OFF_FRAMES    = 12'h034;

  // Field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_BND_LSB   = 8;
  localparam int SHP_LIM_LSB    = 0;
  localparam int SHP_RATE_LSB   = 16;
  localparam int SHP_EN_BIT     = 31;
  localparam int ST_PEND_LSB    = 0;
  localparam int ST_SHAPED_LSB  = 8;
  localparam int ST_PORT_BIT    = 16;
  localparam int ST_PAUSE_BIT   = 17;
  localparam int ST_BUSY_BIT    = 18;

  // Reset values
  localparam logic [1:0]  RST_MODE     = 2'h0;
  localparam logic [3:0]  RST_BOUNDARY = 4'h8;
  localparam logic [31:0] RST_WEIGHT   = 32'h01010101;
  localparam logic [31:0] RST_SHAPER   = 32'h00000000;

  typedef enum logic [1:0] {
    MODE_STRICT = 2'h0,
    MODE_DWRR   = 2'h1,
    MODE_FRR    = 2'h2
  } sched_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_OFFER = 2'b01,
    ST_BUSY  = 2'b11
  } sched_state_t;

  typedef struct packed {
    logic [2:0]       ingress;
    logic [2:0]       cls;
    logic [LEN_W-1:0] len;
  } grant_t;

  typedef struct packed {
    logic              en;
    logic [RATE_W-1:0] rate;
    logic [LIM_W-1:0]  limit;
  } shaper_cfg_t;

endpackage : egress_sched_pkg
`default_nettype wire

// File: hdl/leaky_bucket.sv
`timescale 1ns/10ps
`default_nettype none
module leaky_bucket
  import egress_sched_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             tick,
  input  wire shaper_cfg_t      cfg,
  input  wire logic             charge,
  input  wire logic [LEN_W-1:0] charge_len,
  output logic                  over
);

  logic [LVL_W-1:0] level_q;
  logic [LVL_W-1:0] level_d;
  logic [LVL_W-1:0] filled;
  logic [LVL_W-1:0] drain;

  always_comb begin
    filled = charge ? level_q + LVL_W'(charge_len) : level_q;
    drain  = LVL_W'(cfg.rate);
    if (!cfg.en) begin
      level_d = '0;
    end else if (tick) begin
      level_d = (filled > drain) ? filled - drain : '0;
    end else begin
      level_d = filled;
    end
  end

  // Bucket fill level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

  assign over = cfg.en && (level_q >= LVL_W'(cfg.limit));

  a_bucket_drain: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cfg.en && tick && !charge && (level_q >= LVL_W'(cfg.rate))
    |=> level_q == $past(level_q) - LVL_W'($past(cfg.rate)))
    else $error("bucket did not drain by rate");

  a_bucket_holds: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cfg.en && !tick && !charge |=> level_q == $past(level_q))
    else $error("bucket level moved between ticks");

endmodule : leaky_bucket
`default_nettype wire

// File: verification/egress_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module egress_far_model
  import egress_sched_pkg::*;
#(
  parameter int NI       = NUM_INGRESS,
  parameter int DONE_CYC = 6
) (
  input  wire logic                              sys_clk,
  input  wire logic                              nrst,
  input  wire logic                              ld,
  input  wire logic [2:0]                        ld_i,
  input  wire logic [2:0]                        ld_c,
  input  wire logic [3:0]                        ld_n,
  input  wire logic                              slow,
  output logic [NI-1:0][NUM_CLASS-1:0]           q_valid,
  output logic [NI-1:0][NUM_CLASS-1:0][LEN_W-1:0] q_len,
  input  wire logic                              q_pop,
  input  wire grant_t                            q_pop_sel,
  input  wire logic                              frame_valid,
  output logic                                   frame_ready,
  output logic                                   frame_done
);
  logic [3:0] cnt_q [NI][NUM_CLASS]; // Frames held once, counted
  logic [2:0] wait_q;
  logic [3:0] done_q;
  logic       flip_q;

  always_comb begin
    for (int i = 0; i < NI; i++) begin
      for (int c = 0; c < NUM_CLASS; c++) begin
        q_valid[i][c] = (cnt_q[i][c] != 4'h0);
        q_len[i][c]   = LEN_W'(100 + 4 * c + i);
        if (!q_valid[i][c]) begin
          q_len[i][c] = {LEN_W{flip_q}} ^ 14'h2aaa;
        end
      end
    end
  end

  // Slow mode holds ready back three cycles
  assign frame_ready = frame_valid && (wait_q >= (slow ? 3'h3 : 3'h0));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q      <= '{default: '0};
      wait_q     <= '0;
      done_q     <= '0;
      flip_q     <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      flip_q <= !flip_q;
      for (int i = 0; i < NI; i++) begin
        for (int c = 0; c < NUM_CLASS; c++) begin
          cnt_q[i][c] <= cnt_q[i][c]
            + ((ld && ld_i == 3'(i) && ld_c == 3'(c)) ? ld_n : 4'h0)
            - ((q_pop && q_pop_sel.ingress == 3'(i)
                && q_pop_sel.cls == 3'(c)) ? 4'h1 : 4'h0);
        end
      end
      wait_q <= (frame_valid && !frame_ready) ? wait_q + 3'h1 : 3'h0;
      if (frame_valid && frame_ready) begin
        done_q <= 4'(DONE_CYC);
      end else if (done_q != 4'h0) begin
        done_q <= done_q - 4'h1;
      end
      frame_done <= (done_q == 4'h1);
    end
  end
endmodule : egress_far_model
`default_nettype wire

// File: verification/test_egress_qos_scheduler.sv
`timescale 1ns/10ps
`default_nettype none
module test_egress_qos_scheduler
  import egress_sched_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic        e;
  } row_t;

  logic                                     sys_clk;
  logic                                     nrst;
  logic                                     psel;
  logic                                     penable;
  logic                                     pwrite;
  logic                                     pready;
  logic                                     pslverr;
  logic [11:0]                              paddr;
  logic [31:0]                              pwdata;
  logic [31:0]                              prdata;
  logic [NUM_INGRESS-1:0][NUM_CLASS-1:0]    q_valid;
  logic [NUM_INGRESS-1:0][NUM_CLASS-1:0][LEN_W-1:0] q_len;
  logic                                     q_pop;
  logic                                     frame_valid;
  logic                                     frame_ready;
  logic                                     frame_done;
  logic                                     pause_active;
  grant_t                                   q_pop_sel;
  grant_t                                   frame_info;
  logic                                     ld;
  logic                                     slow;
  logic [2:0]                               ld_i;
  logic [2:0]                               ld_c;
  logic [3:0]                               ld_n;
  int                                       failures;
  int                                       checks;
  grant_t                                   grants[$];

  egress_qos_scheduler i_egress_qos_scheduler (
    .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .q_valid(q_valid), .q_len(q_len),
    .q_pop(q_pop), .q_pop_sel(q_pop_sel), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_info(frame_info),
    .frame_done(frame_done), .pause_active(pause_active)
  );

  egress_far_model i_egress_far_model (
    .sys_clk(sys_clk), .nrst(nrst), .ld(ld), .ld_i(ld_i), .ld_c(ld_c),
    .ld_n(ld_n), .slow(slow), .q_valid(q_valid), .q_len(q_len),
    .q_pop(q_pop), .q_pop_sel(q_pop_sel), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_done(frame_done)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (nrst === 1'b1 && frame_valid === 1'b1 && frame_ready === 1'b1) begin
      grants.push_back(frame_info);
      check(32'(q_pop), 32'h1);
      check(32'(q_pop_sel), 32'(frame_info));
    end else if (nrst === 1'b1) begin
      check(32'(q_pop), 32'h0);
    end
  end

  task automatic test_done;
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic load(input int i, input int c, input int n);
    @(posedge sys_clk);
    ld   <= 1'b1;
    ld_i <= 3'(i);
    ld_c <= 3'(c);
    ld_n <= 4'(n);
    @(posedge sys_clk);
    ld <= 1'b0;
  endtask : load

  task automatic await(input int n, input int lim);
    int k;
    k = 0;
    while (grants.size() < n && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    check(32'(grants.size()), 32'(n));
  endtask : await

  task automatic check_grant(input int k, input int c);
    check(32'(grants[k].cls), 32'(c));
    check(32'(grants[k].len), 32'(100 + 4 * c + grants[k].ingress));
  endtask : check_grant

  initial begin
    #60000;
    failures++;
    test_done();
  end

  initial begin
    row_t        rows[10];
    logic [31:0] rd;
    logic        err;
    rows = '{'{12'h000, 32'h00000800, 1'b0}, '{12'h004, 32'h01010101, 1'b0},
             '{12'h008, 32'h01010101, 1'b0}, '{12'h00c, 32'h00000000, 1'b0},
             '{12'h010, 32'h00000000, 1'b0}, '{12'h02c, 32'h00000000, 1'b0},
             '{12'h030, 32'h00020000, 1'b0}, '{12'h034, 32'h00000000, 1'b0},
             '{12'h040, 32'h00000000, 1'b1}, '{12'hffc, 32'h00000000, 1'b1}};
    nrst = 1'b0;
    {psel, penable, pwrite, ld, slow} = '0;
    {paddr, pwdata, ld_i, ld_c, ld_n} = '0;
    pause_active = 1'b1;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[k]) begin
      apb(1'b0, rows[k].a, 32'h0, rd, err);
      check(rd, rows[k].d);
      check(32'(err), 32'(rows[k].e));
    end
    // Strict order and ingress turns, loaded under pause
    load(0, 7, 1);
    load(0, 3, 2);
    load(1, 3, 2);
    load(2, 0, 1);
    repeat (30) @(posedge sys_clk);
    check(32'(grants.size()), 32'h0);
    pause_active <= 1'b0;
    await(6, 400);
    foreach (grants[k]) begin
      check_grant(k, (k == 0) ? 7 : (k == 5) ? 0 : 3);
      if (k > 1 && k < 5) begin
        check(32'(grants[k].ingress != grants[k-1].ingress), 32'h1);
      end
    end
    // Strict from boundary 4 up, weighted below, class 1 weight 0
    grants.delete();
    apb(1'b1, OFF_CTRL, 32'h00000401, rd, err);
    apb(1'b1, OFF_WEIGHT_LO, 32'h1f01001f, rd, err);
    apb(1'b0, OFF_WEIGHT_LO, 32'h0, rd, err);
    check(rd, 32'h1f01001f);
    pause_active <= 1'b1;
    load(1, 1, 1);
    load(2, 2, 1);
    load(3, 4, 1);
    pause_active <= 1'b0;
    await(2, 1000);
    check_grant(0, 4);
    check_grant(1, 2);
    repeat (200) @(posedge sys_clk);
    check(32'(grants.size()), 32'h2);
    apb(1'b1, OFF_CTRL, 32'h00000800, rd, err);
    await(3, 200);
    // Frame round robin over two classes, slow partner
    grants.delete();
    apb(1'b1, OFF_CTRL, 32'h00000802, rd, err);
    pause_active <= 1'b1;
    load(0, 5, 2);
    load(0, 2, 2);
    slow <= 1'b1;
    pause_active <= 1'b0;
    await(4, 400);
    for (int k = 1; k < 4; k++) begin
      check(32'(grants[k].cls != grants[k-1].cls), 32'h1);
    end
    // Port shaper: limit 64 bytes, 8 bytes per tick
    grants.delete();
    slow <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h00000800, rd, err);
    apb(1'b1, OFF_PORT_SHP, 32'h80080040, rd, err);
    load(0, 0, 2);
    await(1, 100);
    repeat (600) @(posedge sys_clk);
    apb(1'b0, OFF_STATUS, 32'h0, rd, err);
    check(32'(rd[ST_PORT_BIT]), 32'h1);
    check(32'(rd[ST_PEND_LSB]), 32'h1);
    repeat (290) @(posedge sys_clk);
    check(32'(grants.size()), 32'h1);
    await(2, 2000);
    apb(1'b1, OFF_PORT_SHP, 32'h0, rd, err);
    // Mid-run reset brings back strict default
    apb(1'b1, OFF_CTRL, 32'h00000401, rd, err);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0, rd, err);
    check(rd, 32'h00000800);
    test_done();
  end
endmodule : test_egress_qos_scheduler
`default_nettype wire
